// File: hw/supply_ctrl_pkg.sv
// Purpose: Shared constants and carriers for the display bias-supply control
// Assumes: One 10 MHz clock, settings arrive as plain ports
// Notes: Reset values are neutral defaults
package supply_ctrl_pkg;
  // ==========================================================
  // Supply select codes
  localparam logic [1:0] SUPPLY_VDD_MID = 2'h0;
  localparam logic [1:0] SUPPLY_VDD_HIGH = 2'h1;
  localparam logic [1:0] SUPPLY_LOW_VOLT = 2'h2;
  localparam logic [1:0] SUPPLY_EXTERNAL = 2'h3;
  // ==========================================================
  // Reset values
  localparam logic [1:0] RST_SUPPLY_SELECT = 2'h0;
  localparam logic RST_BUFFER_BYPASS = 1'b0;
  localparam logic RST_PUMP_ENABLE = 1'b0;
  localparam logic RST_REGULATOR_ENABLE = 1'b0;
  localparam logic RST_REF_LEVEL = 1'b0;
  localparam logic [3:0] RST_TRIM = 4'h0;
  localparam logic [2:0] RST_FRAME_CLOCK_DIV = 3'h0;
  localparam logic [2:0] RST_BLINK_RATE = 3'h0;
  localparam logic [2:0] RST_DUTY = 3'h3;
  localparam logic [1:0] RST_BIAS = 2'h2;
  // ==========================================================
  // Trim: signed steps of 1.5 percent, range limited to +/-12 percent
  localparam int TRIM_STEP_TENTHS_PCT = 15;
  localparam int TRIM_LIMIT_TENTHS_PCT = 120;
  localparam logic signed [4:0] TRIM_MAX_STEPS = 5'(TRIM_LIMIT_TENTHS_PCT / TRIM_STEP_TENTHS_PCT);
  // ==========================================================
  // Carriers
  typedef struct packed {
    logic [1:0] supply_select;
    logic ref_level_select;
    logic buffer_bypass;
    logic pump_enable;
    logic regulator_enable;
    logic [3:0] trim;
    logic [2:0] frame_clock_div;
    logic [2:0] blink_rate;
    logic panel_enable;
    logic frame_irq_enable;
  } config_s;
  typedef struct packed {
    logic power_switch_a;
    logic power_switch_b;
    logic power_switch_c;
    logic ref_buffer_on;
    logic low_volt_input_oe;
    logic [1:0] divider_tap;
    logic regulated_ref_to_low;
    logic ref_level_high;
    logic signed [4:0] trim_steps;
    logic mid_bias_internal;
  } switches_s;
endpackage

// File: hw/supply_decode.sv
// Purpose: Combinational decode of supply settings into switch enables
// Assumes: Inputs already registered
// Notes: Result is registered by the caller
module supply_decode
  import supply_ctrl_pkg::*;
(
  input wire supply_ctrl_pkg::config_s cfg,
  output supply_ctrl_pkg::switches_s sw
);
  always_comb begin
    sw = '0;
    // ==========================================================
    // Power switches
    case (cfg.supply_select)
      SUPPLY_VDD_MID: begin
        sw.power_switch_a = 1'b1;
      end
      SUPPLY_VDD_HIGH: begin
        sw.power_switch_b = 1'b1;
      end
      SUPPLY_LOW_VOLT: begin
        sw.power_switch_c = 1'b1;
      end
      default: begin
        sw.power_switch_a = 1'b0;
      end
    endcase
    sw.ref_buffer_on = ~cfg.buffer_bypass & sw.power_switch_c;
    // Pin tri-stated unless the buffer drives it
    sw.low_volt_input_oe = sw.ref_buffer_on;
    sw.divider_tap = {cfg.ref_level_select, ~cfg.buffer_bypass & sw.power_switch_c};
    sw.regulated_ref_to_low = cfg.regulator_enable;
    sw.ref_level_high = cfg.ref_level_select;
    // Clamp so out-of-range trim never exceeds the allowed span
    if ($signed(cfg.trim) > TRIM_MAX_STEPS)
      sw.trim_steps = TRIM_MAX_STEPS;
    else if ($signed(cfg.trim) < -TRIM_MAX_STEPS)
      sw.trim_steps = -TRIM_MAX_STEPS;
    else
      sw.trim_steps = 5'($signed(cfg.trim));
    sw.mid_bias_internal = cfg.pump_enable;
  end
endmodule

// File: hw/lcd_supply_switch_ctrl.sv
// Purpose: Bias-supply switch control and frame-event flag
// Assumes: Settings are plain ports synchronous to REF_CLK
// Notes: Analog generation lives outside
module lcd_supply_switch_ctrl
  import supply_ctrl_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic ARST_N,
  input wire supply_ctrl_pkg::config_s CONFIG,
  input wire logic CONFIG_WRITE,
  input wire logic FRAME_EVENT,
  input wire logic FLAG_WRITE,
  input wire logic FLAG_WRITE_DATA,
  output supply_ctrl_pkg::config_s ACTIVE_CONFIG,
  output supply_ctrl_pkg::switches_s SWITCHES,
  output logic [2:0] DUTY,
  output logic [1:0] BIAS,
  output logic DRIVERS_OE,
  output logic FRAME_EVENT_FLAG,
  output logic IRQ
);
  import supply_ctrl_pkg::*;
  // ==========================================================
  // Reset release
  // Assert is immediate; release passes two flops
  // so no register leaves reset close to a clock edge
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ==========================================================
  // Settings
  // Whole bundle loads in one edge so a half-written supply code
  // never reaches the switches
  // Trim is carried as is; the decode clamps it
  localparam config_s CFG_RESET = '{
    supply_select: RST_SUPPLY_SELECT,
    ref_level_select: RST_REF_LEVEL,
    buffer_bypass: RST_BUFFER_BYPASS,
    pump_enable: RST_PUMP_ENABLE,
    regulator_enable: RST_REGULATOR_ENABLE,
    trim: RST_TRIM,
    frame_clock_div: RST_FRAME_CLOCK_DIV,
    blink_rate: RST_BLINK_RATE,
    panel_enable: 1'b0,
    frame_irq_enable: 1'b0
  };

  config_s cfg;
  config_s next_cfg;

  always_comb begin
    next_cfg = cfg;
    if (CONFIG_WRITE) begin
      next_cfg = CONFIG;
    end
  end

  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      cfg <= CFG_RESET;
    end else begin
      cfg <= next_cfg;
    end
  end

  // ==========================================================
  // Switch decode
  // Decode runs on the registered bundle and is registered again,
  // so the switches settle one cycle after the settings
  // Reset shows every switch open until the first decode
  switches_s sw_comb;
  switches_s sw;
  switches_s next_sw;

  supply_decode u_decode (
    .cfg(cfg),
    .sw(sw_comb)
  );

  always_comb begin
    next_sw = sw_comb;
  end

  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      sw <= '0;
    end else begin
      sw <= next_sw;
    end
  end

  // ==========================================================
  // Frame-event flag
  // Set wins over a same-cycle clear so no event is ever lost
  // A write of zero leaves the flag alone
  logic flag;
  logic next_flag;
  logic flag_clear;

  always_comb begin
    flag_clear = FLAG_WRITE & FLAG_WRITE_DATA;
    next_flag = flag;
    if (flag_clear) begin
      next_flag = 1'b0;
    end
    if (FRAME_EVENT) begin
      next_flag = 1'b1;
    end
  end

  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      flag <= 1'b0;
    end else begin
      flag <= next_flag;
    end
  end

  // ==========================================================
  // Interrupt request
  // Built from next values so the request rises with the flag
  // Level output, held while both bits stay set
  logic irq;
  logic next_irq;

  always_comb begin
    next_irq = next_flag & next_cfg.frame_irq_enable;
  end

  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= next_irq;
    end
  end

  // ==========================================================
  // Driver enable
  // Low keeps every segment and backplane driver floating
  // Follows the panel-enable bit of the bundle
  logic drivers_oe;
  logic next_drivers_oe;

  always_comb begin
    next_drivers_oe = next_cfg.panel_enable;
  end

  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      drivers_oe <= 1'b0;
    end else begin
      drivers_oe <= next_drivers_oe;
    end
  end

  // ==========================================================
  // Duty and bias
  // No programming path here; both hold their defaults
  // Kept as registers so a later write path drops in here
  logic [2:0] duty;
  logic [1:0] bias;
  logic [2:0] next_duty;
  logic [1:0] next_bias;

  always_comb begin
    next_duty = RST_DUTY;
    next_bias = RST_BIAS;
  end

  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      duty <= RST_DUTY;
      bias <= RST_BIAS;
    end else begin
      duty <= next_duty;
      bias <= next_bias;
    end
  end

  // ==========================================================
  // Outputs
  // Every output is a plain copy of a register above
  assign ACTIVE_CONFIG = cfg;
  assign SWITCHES = sw;
  assign DUTY = duty;
  assign BIAS = bias;

  assign DRIVERS_OE = drivers_oe;
  assign FRAME_EVENT_FLAG = flag;
  assign IRQ = irq;
endmodule

// File: verification/supply_checker.sv
// Purpose: Port checker for supply switch control
// Assumes: Reset release takes two edges
// Notes: Checks wait three edges after reset
module supply_checker
  import supply_ctrl_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic ARST_N,
  input wire supply_ctrl_pkg::config_s CONFIG,
  input wire logic CONFIG_WRITE,
  input wire logic FRAME_EVENT,
  input wire logic FLAG_WRITE,
  input wire logic FLAG_WRITE_DATA,
  input wire supply_ctrl_pkg::config_s ACTIVE_CONFIG,
  input wire supply_ctrl_pkg::switches_s SWITCHES,
  input wire logic DRIVERS_OE,
  input wire logic FRAME_EVENT_FLAG,
  input wire logic IRQ
);
  timeunit 1ns;
  timeprecision 1ns;
  // ====================
  // Properties
  logic [2:0] up;
  logic [2:0] next_up;
  wire [2:0] sw = {SWITCHES.power_switch_a, SWITCHES.power_switch_b, SWITCHES.power_switch_c};
  // Outputs still hold reset values while the synchroniser drains
  always_comb next_up = {up[1:0], 1'b1};
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) up <= 3'h0;
    else up <= next_up;
  end
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!up[2]);
  sequence s_clear; FLAG_WRITE && FLAG_WRITE_DATA && !FRAME_EVENT; endsequence
  sequence s_hold; FRAME_EVENT_FLAG && !FRAME_EVENT && !(FLAG_WRITE && FLAG_WRITE_DATA); endsequence
  property p_low; ACTIVE_CONFIG.supply_select == 2'h2 |=> sw == 3'h1; endproperty
  property p_ext; ACTIVE_CONFIG.supply_select == 2'h3 |=> sw == 3'h0; endproperty
  property p_buf; 1'b1 |=> SWITCHES.ref_buffer_on == (!$past(ACTIVE_CONFIG.buffer_bypass) && sw[0]);
  endproperty
  property p_reg; 1'b1 |=> SWITCHES.regulated_ref_to_low == $past(ACTIVE_CONFIG.regulator_enable);
  endproperty
  property p_load; CONFIG_WRITE |=> DRIVERS_OE == $past(CONFIG.panel_enable); endproperty
  property p_set; FRAME_EVENT |=> FRAME_EVENT_FLAG; endproperty
  property p_clr; s_clear |=> !FRAME_EVENT_FLAG; endproperty
  property p_keep; s_hold |=> FRAME_EVENT_FLAG; endproperty
  property p_irq; IRQ == (FRAME_EVENT_FLAG && ACTIVE_CONFIG.frame_irq_enable); endproperty
  a_low: assert property (p_low) else $error("bad switches code 2");
  a_ext: assert property (p_ext) else $error("bad switches code 3");
  a_buf: assert property (p_buf) else $error("bad buffer enable");
  a_reg: assert property (p_reg) else $error("bad reference route");
  a_load: assert property (p_load) else $error("bad driver enable");
  a_set: assert property (p_set) else $error("flag not set");
  a_clr: assert property (p_clr) else $error("flag not cleared");
  a_keep: assert property (p_keep) else $error("flag lost");
  a_irq: assert property (p_irq) else $error("bad irq");
endmodule
bind lcd_supply_switch_ctrl supply_checker chk_i (.REF_CLK(REF_CLK), .ARST_N(ARST_N),
  .CONFIG(CONFIG), .CONFIG_WRITE(CONFIG_WRITE), .FRAME_EVENT(FRAME_EVENT),
  .FLAG_WRITE(FLAG_WRITE), .FLAG_WRITE_DATA(FLAG_WRITE_DATA), .ACTIVE_CONFIG(ACTIVE_CONFIG),
  .SWITCHES(SWITCHES), .DRIVERS_OE(DRIVERS_OE), .FRAME_EVENT_FLAG(FRAME_EVENT_FLAG), .IRQ(IRQ));

// File: verification/lcd_supply_switch_ctrl_tb.sv
// Purpose: Directed bench for supply switch control
// Assumes: Two-flop reset release
// Notes: Switch decode lags a write by two edges
module lcd_supply_switch_ctrl_tb import supply_ctrl_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  // ====================
  // Stimulus
  logic clk = 1'b0, rst_n = 1'b0, cfg_wr = 1'b0, ev = 1'b0, fw = 1'b0, fd = 1'b0;
  logic oe, flag, irq, on;
  config_s cfg = '0, act, c;
  switches_s sw;
  logic [2:0] duty;
  logic [1:0] bias;
  int errors = 0, tests_run = 0;
  always #50 clk = ~clk;
  lcd_supply_switch_ctrl DUT (.REF_CLK(clk), .ARST_N(rst_n), .CONFIG(cfg), .CONFIG_WRITE(cfg_wr),
    .FRAME_EVENT(ev), .FLAG_WRITE(fw), .FLAG_WRITE_DATA(fd), .ACTIVE_CONFIG(act), .SWITCHES(sw),
    .DUTY(duty), .BIAS(bias), .DRIVERS_OE(oe), .FRAME_EVENT_FLAG(flag), .IRQ(irq));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("Checks %0d, errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic load(input config_s v);
    @(posedge clk);
    cfg <= v;
    cfg_wr <= 1'b1;
    @(posedge clk);
    cfg_wr <= 1'b0;
    @(posedge clk);
    #1;
  endtask
  // Irq enable is on here, so irq follows the flag
  task automatic hit(input logic e, input logic w, input logic d, input logic x);
    @(posedge clk);
    ev <= e;
    fw <= w;
    fd <= d;
    @(posedge clk);
    ev <= 1'b0;
    fw <= 1'b0;
    fd <= 1'b0;
    #1;
    chk({flag, irq}, {x, x});
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk(oe, 0);
    chk({act, duty, bias}, {18'h0, RST_DUTY, RST_BIAS});
    for (int i = 0; i < 8; i++) begin
      c = '0;
      c.supply_select = i[1:0];
      c.buffer_bypass = i[2];
      c.ref_level_select = i[2] ^ i[0];
      c.pump_enable = i[0] | ~i[1];
      c.regulator_enable = i[1];
      c.trim = 4'(i * 5 - 8);
      on = !c.buffer_bypass && i[1:0] == 2'h2;
      load(c);
      chk({sw.power_switch_a, sw.power_switch_b, sw.power_switch_c}, 4 >> i[1:0]);
      chk({sw.ref_buffer_on, sw.low_volt_input_oe}, {on, on});
      chk(sw.divider_tap, {c.ref_level_select, on});
      chk({sw.regulated_ref_to_low, sw.ref_level_high}, {c.regulator_enable, c.ref_level_select});
      chk({sw.trim_steps}, {c.trim[3], c.trim});
      chk(sw.mid_bias_internal, c.pump_enable);
    end
    c = '0;
    c.panel_enable = 1'b1;
    c.frame_irq_enable = 1'b1;
    load(c);
    chk(oe, 1);
    hit(1, 0, 0, 1);
    hit(0, 1, 0, 1);
    hit(1, 1, 1, 1);
    hit(0, 1, 1, 0);
    // Enable off: flag sets but no request
    c.frame_irq_enable = 1'b0;
    load(c);
    @(posedge clk);
    ev <= 1'b1;
    @(posedge clk);
    ev <= 1'b0;
    #1;
    chk({flag, irq}, 2'b10);
    // Mid-run reset drops the programmed settings and the flag
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk({oe, flag, irq}, 3'b000);
    chk({act, duty, bias}, {18'h0, RST_DUTY, RST_BIAS});
    complete_run();
  end
  initial begin
    #20000;
    errors++;
    complete_run();
  end
endmodule
